// >>> core/op_timing_pkg.sv
// Package: opcode patterns, clock counts and pipeline timing constants
package op_timing_pkg;
  // Opcode patterns (width bit masked where applicable)
  localparam logic [7:0] OPC_GRP3        = 8'hF6; // 1111011w
  localparam logic [7:0] OPC_AND_RM      = 8'h84; // 1000010w
  localparam logic [7:0] OPC_AND_ACC     = 8'hA8; // 1010100w
  localparam logic [7:0] OPC_COPY        = 8'hA4; // 1010010w
  localparam logic [7:0] OPC_PIN         = 8'h6C; // 0110110w
  localparam logic [7:0] OPC_POUT        = 8'h6E; // 0110111w
  localparam logic [7:0] OPC_CMP         = 8'hA6; // 1010011w
  localparam logic [7:0] OPC_FILL        = 8'hAA; // 1010101w
  localparam logic [7:0] OPC_SCAN        = 8'hAE; // 1010111w
  localparam logic [7:0] OPC_REP         = 8'hF2; // 11110010
  localparam logic [7:0] OPC_REPZ_BASE   = 8'hF2; // 1111001z
  localparam logic [7:0] OPC_BEQ         = 8'h74;
  localparam logic [7:0] OPC_BNE         = 8'h75;
  localparam logic [7:0] OPC_RET         = 8'hC3;
  localparam logic [7:0] OPC_RET_IMM     = 8'hC2;
  localparam logic [7:0] OPC_RETF        = 8'hCB;
  localparam logic [7:0] OPC_LOOPNZ      = 8'hE0;
  localparam logic [7:0] OPC_LOOPZ       = 8'hE1;
  localparam logic [7:0] OPC_LOOP        = 8'hE2;
  localparam logic [7:0] OPC_BCZ         = 8'hE3;
  localparam logic [7:0] OPC_OVF         = 8'hCE;
  localparam logic [7:0] OPC_RANGE       = 8'h62;
  localparam logic [7:0] OPC_LOCK        = 8'hF0;
  localparam logic [7:0] OPC_ESC         = 8'hD8; // 11011MMM
  localparam logic [2:0] REG_NOT         = 3'h2;
  localparam logic [2:0] REG_TEST        = 3'h0;
  localparam logic [2:0] REG_MUL         = 3'h4;
  localparam logic [2:0] REG_DIV         = 3'h6;
  // Clock counts
  localparam logic [15:0] CLK_ONE        = 16'h0001;
  localparam logic [15:0] CLK_NOT_MEM    = 16'h0007;
  localparam logic [15:0] CLK_TEST_IMM   = 16'h0008;
  localparam logic [15:0] CLK_STR_MOVE   = 16'h000D;
  localparam logic [15:0] CLK_STR_CMP    = 16'h0012;
  localparam logic [15:0] CLK_STR_FILL   = 16'h0007;
  localparam logic [15:0] CLK_STR_SCAN   = 16'h000D;
  localparam logic [15:0] CLK_REP_BASE4  = 16'h0004;
  localparam logic [15:0] CLK_REP_BASE5  = 16'h0005;
  localparam logic [15:0] CLK_REP_STEP9  = 16'h0009;
  localparam logic [15:0] CLK_BR_TAKEN   = 16'h0009;
  localparam logic [15:0] CLK_RET_NEAR   = 16'h0010;
  localparam logic [15:0] CLK_RET_FAR    = 16'h0017;
  localparam logic [15:0] CLK_LOOP_NT    = 16'h0007;
  localparam logic [15:0] CLK_LOOP_T     = 16'h0010;
  localparam logic [15:0] CLK_BCZ_T      = 16'h000F;
  localparam logic [15:0] CLK_OVF_TRAP   = 16'h002B;
  localparam logic [15:0] CLK_OVF_NONE   = 16'h0004;
  localparam logic [15:0] CLK_RANGE_MIN  = 16'h0015;
  localparam logic [15:0] CLK_RANGE_MAX  = 16'h003C;
  // Micro-step cycle counts
  localparam logic [4:0] CYC_MEM_READ    = 5'h06;
  localparam logic [4:0] CYC_PUSH        = 5'h01;
  localparam logic [4:0] CYC_PUSH_STALL  = 5'h05;
  localparam logic [4:0] CYC_MULDIV_B    = 5'h08;
  localparam logic [4:0] CYC_MULDIV_W    = 5'h10;
  localparam logic [4:0] CYC_REFETCH     = 5'h09;
  // Instruction classes
  typedef enum logic [4:0] {
    CL_NONE, CL_INVERT, CL_AND_FLAGS, CL_COPY, CL_PORT_IN, CL_PORT_OUT,
    CL_CMP, CL_FILL, CL_SCAN, CL_BRANCH, CL_RET, CL_LOOP, CL_BCZ,
    CL_OVF, CL_RANGE, CL_LOCK, CL_ESC, CL_MULDIV
  } op_class_t;
  // Micro-step kinds
  typedef enum logic [2:0] {
    US_ALU, US_MEM, US_READ, US_PUSH, US_WRITE, US_MULDIV, US_REFETCH
  } ustep_t;
endpackage

// >>> core/cisc_opcode_decode_timing.sv
// Opcode decoder with minimum clock-count assignment and micro-step pipeline timing
//
// Overview of operation
// - Invert operand: 1 clock reg, 7 memory
// - Flag-only AND forms, result discarded
// - Copy and port strings take 13
// - String compare takes 18 clocks
// - String fill takes 7 clocks
// - Repeat prefix: 4+9n or 5+9n
// - Conditional repeat: compare 4+18n, scan 4+13n
// - Conditional branch: 1 not taken, 9 taken
// - Subroutine exit 16, 16, 23 clocks
// - Count loops 7/16, count-zero branch 7/15
// - Overflow trap 43 when set, else 4
// - Range check takes 21 to 60
// - Lock prefix 1 clock, locks next instruction
// - Coprocessor escape accepted, 1 core clock
// - Counts are minima, ideal queue and bus
// - Single micro-step occupies 1 cycle
// - Memory read occupies 6 cycles
// - Push after push/write takes 5 cycles
// - Multiply/divide 8 byte, 16 word cycles
// - Destination refetch takes 9 cycles
`timescale 1ns/100ps
module cisc_opcode_decode_timing
  import op_timing_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             dec_valid,
  input  wire logic             prefix_byte_valid,
  input  wire logic [7:0]       prefix_byte,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       modrm,
  input  wire logic [7:0]       branch_offset,
  input  wire logic [15:0]      next_ip,
  input  wire logic             cond_true,
  input  wire logic             overflow_flag,
  input  wire logic [15:0]      count_reg,
  input  wire logic [5:0]       range_cycles,
  input  wire logic             ustep_valid,
  input  wire ustep_t           ustep_kind,
  input  wire logic             ustep_word,
  output logic                  dec_done,
  output op_class_t             op_class,
  output logic                  op_word,
  output logic [1:0]            imm_bytes,
  output logic                  flags_only,
  output logic                  trap_raise,
  output logic                  bus_lock,
  output logic                  coproc_escape,
  output logic [15:0]           branch_target,
  output logic [CNT_W-1:0]      op_clocks,
  output logic                  ustep_ready,
  output logic                  wb_valid,
  output ustep_t                wb_kind
);

  // Later checks share the core clock and reset
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  // Class decode, width bit stripped where the pattern carries one
  wire logic [7:0] op_w     = {opcode[7:1], 1'b0};
  wire logic [2:0] reg_fld  = modrm[5:3];
  wire logic       rm_mem   = (modrm[7:6] != 2'b11);
  wire logic       is_rep   = prefix_byte_valid && (prefix_byte == OPC_REP);
  wire logic       is_repz  = prefix_byte_valid && ({prefix_byte[7:1], 1'b0} == OPC_REPZ_BASE);
  wire logic       is_lockp = prefix_byte_valid && (prefix_byte == OPC_LOCK);
  op_class_t       cls;

  always_comb begin
    cls = CL_NONE;
    if (op_w == OPC_GRP3 && reg_fld == REG_NOT)                cls = CL_INVERT;
    else if (op_w == OPC_GRP3 && reg_fld == REG_TEST)          cls = CL_AND_FLAGS;
    else if (op_w == OPC_GRP3 && reg_fld[2:1] == REG_MUL[2:1]) cls = CL_MULDIV;
    else if (op_w == OPC_GRP3 && reg_fld[2:1] == REG_DIV[2:1]) cls = CL_MULDIV;
    else if (op_w == OPC_AND_RM || op_w == OPC_AND_ACC)        cls = CL_AND_FLAGS;
    else if (op_w == OPC_COPY)                                 cls = CL_COPY;
    else if (op_w == OPC_PIN)                                  cls = CL_PORT_IN;
    else if (op_w == OPC_POUT)                                 cls = CL_PORT_OUT;
    else if (op_w == OPC_CMP)                                  cls = CL_CMP;
    else if (op_w == OPC_FILL)                                 cls = CL_FILL;
    else if (op_w == OPC_SCAN)                                 cls = CL_SCAN;
    else if (opcode[7:4] == 4'h7)                              cls = CL_BRANCH;
    else if (opcode == OPC_RET || opcode == OPC_RET_IMM || opcode == OPC_RETF)
      cls = CL_RET;
    else if (opcode == OPC_LOOP || opcode == OPC_LOOPZ || opcode == OPC_LOOPNZ)
      cls = CL_LOOP;
    else if (opcode == OPC_BCZ)                                cls = CL_BCZ;
    else if (opcode == OPC_OVF)                                cls = CL_OVF;
    else if (opcode == OPC_RANGE)                              cls = CL_RANGE;
    else if (opcode == OPC_LOCK)                               cls = CL_LOCK;
    else if (opcode[7:3] == OPC_ESC[7:3])                      cls = CL_ESC;
  end

  // ----------------------------------------------------------------
  // Clock-count table (minima under ideal queue and bus)
  // ----------------------------------------------------------------
  // Iteration products; n is the count register value
  wire logic [CNT_W-1:0] n        = CNT_W'(count_reg);
  wire logic [CNT_W-1:0] rep9     = CNT_W'(n * CNT_W'(CLK_REP_STEP9));
  wire logic [CNT_W-1:0] rep18    = CNT_W'(n * CNT_W'(CLK_STR_CMP));
  wire logic [CNT_W-1:0] rep13    = CNT_W'(n * CNT_W'(CLK_STR_SCAN));
  wire logic             loop_tk  = cond_true;
  logic [CNT_W-1:0]      clocks;

  // Taken paths pay the refetch; counts are minima only
  always_comb begin
    clocks = CNT_W'(CLK_ONE);
    unique case (cls)
      CL_INVERT:    clocks = CNT_W'(rm_mem ? CLK_NOT_MEM : CLK_ONE);
      CL_AND_FLAGS: begin
        if (op_w == OPC_AND_ACC)   clocks = CNT_W'(CLK_ONE);
        else if (op_w == OPC_GRP3) clocks = CNT_W'(rm_mem ? CLK_TEST_IMM : CLK_ONE);
        else                       clocks = CNT_W'(rm_mem ? CLK_NOT_MEM : CLK_ONE);
      end
      CL_COPY:      clocks = is_rep ? CNT_W'(CLK_REP_BASE4) + rep9 : CNT_W'(CLK_STR_MOVE);
      CL_PORT_IN,
      CL_PORT_OUT:  clocks = is_rep ? CNT_W'(CLK_REP_BASE5) + rep9 : CNT_W'(CLK_STR_MOVE);
      CL_CMP:       clocks = is_repz ? CNT_W'(CLK_REP_BASE4) + rep18 : CNT_W'(CLK_STR_CMP);
      CL_SCAN:      clocks = is_repz ? CNT_W'(CLK_REP_BASE4) + rep13 : CNT_W'(CLK_STR_SCAN);
      CL_FILL:      clocks = CNT_W'(CLK_STR_FILL);
      CL_BRANCH:    clocks = CNT_W'(loop_tk ? CLK_BR_TAKEN : CLK_ONE);
      CL_RET:       clocks = CNT_W'(opcode == OPC_RETF ? CLK_RET_FAR : CLK_RET_NEAR);
      CL_LOOP:      clocks = CNT_W'(loop_tk ? CLK_LOOP_T : CLK_LOOP_NT);
      CL_BCZ:       clocks = CNT_W'(loop_tk ? CLK_BCZ_T : CLK_LOOP_NT);
      CL_OVF:       clocks = CNT_W'(overflow_flag ? CLK_OVF_TRAP : CLK_OVF_NONE);
      CL_RANGE: begin
        if (CNT_W'(range_cycles) < CNT_W'(CLK_RANGE_MIN))      clocks = CNT_W'(CLK_RANGE_MIN);
        else if (CNT_W'(range_cycles) > CNT_W'(CLK_RANGE_MAX)) clocks = CNT_W'(CLK_RANGE_MAX);
        else                                                   clocks = CNT_W'(range_cycles);
      end
      CL_MULDIV:    clocks = CNT_W'(opcode[0] ? CYC_MULDIV_W : CYC_MULDIV_B);
      CL_LOCK,
      CL_ESC,
      CL_NONE:      clocks = CNT_W'(CLK_ONE);
    endcase
  end

  // Immediate size from width bit, only for immediate forms
  wire logic       has_imm  = (op_w == OPC_AND_ACC) || (cls == CL_AND_FLAGS && op_w == OPC_GRP3);
  wire logic [1:0] imm_next = has_imm ? (opcode[0] ? 2'd2 : 2'd1) : 2'd0;
  // Sign-extended offset relative to the next instruction
  wire logic [15:0] tgt_next = next_ip + {{8{branch_offset[7]}}, branch_offset};

  // ----------------------------------------------------------------
  // Decode result registers
  // ----------------------------------------------------------------
  logic      lock_pend_reg;
  op_class_t cls_reg;

  // Results are registered so downstream sees stable data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_done      <= 1'b0;
      cls_reg       <= CL_NONE;
      op_word       <= 1'b0;
      imm_bytes     <= 2'd0;
      flags_only    <= 1'b0;
      trap_raise    <= 1'b0;
      coproc_escape <= 1'b0;
      branch_target <= 16'h0000;
      op_clocks     <= '0;
      lock_pend_reg <= 1'b0;
      bus_lock      <= 1'b0;
    end else if (clk_en) begin
      dec_done <= dec_valid;
      if (dec_valid) begin
        cls_reg       <= cls;
        op_word       <= opcode[0];
        imm_bytes     <= imm_next;
        flags_only    <= (cls == CL_AND_FLAGS);
        trap_raise    <= (cls == CL_OVF) && overflow_flag;
        coproc_escape <= (cls == CL_ESC);
        branch_target <= tgt_next;
        op_clocks     <= clocks;
        // Lock held across the instruction after the prefix
        lock_pend_reg <= (cls == CL_LOCK);
        bus_lock      <= (cls == CL_LOCK) || lock_pend_reg || is_lockp;
      end
    end
  end
  assign op_class = cls_reg;

  // ----------------------------------------------------------------
  // Micro-step timing pipeline
  // ----------------------------------------------------------------
  // Occupancy per kind; push stalls after push or write
  logic       prev_store_reg;
  logic [4:0] busy_reg;
  ustep_t     kind_reg;
  wire  logic accept = ustep_valid && ustep_ready;
  logic [4:0] occ;

  always_comb begin
    occ = 5'd1;
    unique case (ustep_kind)
      US_ALU, US_MEM, US_WRITE: occ = 5'd1;
      US_READ:    occ = CYC_MEM_READ;
      US_PUSH:    occ = prev_store_reg ? CYC_PUSH_STALL : CYC_PUSH;
      US_MULDIV:  occ = ustep_word ? CYC_MULDIV_W : CYC_MULDIV_B;
      US_REFETCH: occ = CYC_REFETCH;
      default:    occ = 5'd1;
    endcase
  end

  // Later steps wait while a long step drains, keeping order
  assign ustep_ready = (busy_reg == 5'd0);

  // One step in flight; writeback fires when its count expires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg       <= 5'd0;
      kind_reg       <= US_ALU;
      prev_store_reg <= 1'b0;
      wb_valid       <= 1'b0;
      wb_kind        <= US_ALU;
    end else if (clk_en) begin
      wb_valid <= 1'b0;
      if (accept) begin
        busy_reg       <= occ - 5'd1;
        kind_reg       <= ustep_kind;
        prev_store_reg <= (ustep_kind == US_PUSH) || (ustep_kind == US_WRITE);
      end else if (busy_reg != 5'd0) begin
        busy_reg <= busy_reg - 5'd1;
      end
      if ((accept && occ == 5'd1) || (busy_reg == 5'd1)) begin
        wb_valid <= 1'b1;
        wb_kind  <= accept ? ustep_kind : kind_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_read_six;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && accept && ustep_kind == US_READ) ##1 clk_en [*5] |=> wb_valid;
  endproperty
  a_read_six: assert property (p_read_six) else $error("read step not six cycles");

  property p_hold_ready;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && accept && occ != 5'd1) |=> (!ustep_ready && !wb_valid);
  endproperty
  a_hold_ready: assert property (p_hold_ready) else $error("step accepted while busy");

  property p_ovf_trap;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && opcode == OPC_OVF) |=> (trap_raise == $past(overflow_flag));
  endproperty
  a_ovf_trap: assert property (p_ovf_trap) else $error("overflow trap mismatch");

  property p_branch_clk;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && opcode == OPC_BEQ) |=>
        (op_clocks == ($past(cond_true) ? CNT_W'(CLK_BR_TAKEN) : CNT_W'(CLK_ONE)));
  endproperty
  a_branch_clk: assert property (p_branch_clk) else $error("branch clocks wrong");

  property p_target;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid) |=>
        (branch_target == $past(next_ip) + {{8{$past(branch_offset[7])}}, $past(branch_offset)});
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_lock_next;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && opcode == OPC_LOCK) ##1 (clk_en && dec_valid) |=> bus_lock;
  endproperty
  a_lock_next: assert property (p_lock_next) else $error("lock not held over next");

  property p_copy_clk;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && op_w == OPC_COPY && !prefix_byte_valid) |=> (op_clocks == CNT_W'(CLK_STR_MOVE));
  endproperty
  a_copy_clk: assert property (p_copy_clk) else $error("copy clocks wrong");

  property p_fill_clk;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && op_w == OPC_FILL) |=> (op_clocks == CNT_W'(CLK_STR_FILL));
  endproperty
  a_fill_clk: assert property (p_fill_clk) else $error("fill clocks wrong");

  property p_esc;
    @(posedge clk) disable iff (!arst_n)
      (clk_en && dec_valid && opcode[7:3] == OPC_ESC[7:3]) |=> (coproc_escape && op_clocks == CNT_W'(CLK_ONE));
  endproperty
  a_esc: assert property (p_esc) else $error("escape not accepted");

  // Push right behind a push or write pays the bus stall
  sequence s_store_push;
    (clk_en && accept && (ustep_kind == US_PUSH || ustep_kind == US_WRITE))
      ##1 (clk_en && accept && ustep_kind == US_PUSH);
  endsequence

  property p_push_stall;
    s_store_push |=>
      (busy_reg == CYC_PUSH_STALL - 5'd1);
  endproperty
  a_push_stall: assert property (p_push_stall) else $error("push not stalled");

  property p_muldiv_occ;
    (clk_en && accept && ustep_kind == US_MULDIV) |=>
      (busy_reg == ($past(ustep_word) ? CYC_MULDIV_W : CYC_MULDIV_B) - 5'd1);
  endproperty
  a_muldiv_occ: assert property (p_muldiv_occ) else $error("mul/div occupancy wrong");

  property p_refetch;
    (clk_en && accept && ustep_kind == US_REFETCH) |=>
      (busy_reg == CYC_REFETCH - 5'd1);
  endproperty
  a_refetch: assert property (p_refetch) else $error("refetch occupancy wrong");

  property p_single_step;
    (clk_en && accept && ustep_kind == US_ALU) |=>
      (wb_valid && wb_kind == US_ALU && ustep_ready);
  endproperty
  a_single_step: assert property (p_single_step) else $error("single step not one cycle");

  property p_invert_clk;
    (clk_en && dec_valid && op_w == OPC_GRP3 && reg_fld == REG_NOT) |=>
      (op_clocks == ($past(rm_mem) ? CNT_W'(CLK_NOT_MEM) : CNT_W'(CLK_ONE)));
  endproperty
  a_invert_clk: assert property (p_invert_clk) else $error("invert clocks wrong");

  property p_flags_only;
    (clk_en && dec_valid && (op_w == OPC_AND_RM || op_w == OPC_AND_ACC)) |=>
      (flags_only && op_class == CL_AND_FLAGS);
  endproperty
  a_flags_only: assert property (p_flags_only) else $error("flag-only and wrong");

  property p_loop_clk;
    (clk_en && dec_valid && opcode == OPC_LOOP) |=>
      (op_clocks == ($past(cond_true) ? CNT_W'(CLK_LOOP_T) : CNT_W'(CLK_LOOP_NT)));
  endproperty
  a_loop_clk: assert property (p_loop_clk) else $error("loop clocks wrong");

endmodule // cisc_opcode_decode_timing

// >>> test/cisc_opcode_decode_timing_test.sv
// Self-checking bench for the opcode decoder and micro-step timing
`timescale 1ns/100ps
module cisc_opcode_decode_timing_test;
  import op_timing_pkg::*;

  // ------------------------------------------------------------------
  // Signals, expectation records and queues
  // ------------------------------------------------------------------
  typedef struct {logic [15:0] clks; op_class_t cls; logic lock; logic flg; logic trap; logic coproc_handoff;
                  logic tchk; logic [15:0] tgt; logic ichk; logic [1:0] imm; logic wd; int due;} dec_exp_t;
  typedef struct {ustep_t kind; int due;} step_exp_t;
  logic        clk, arst_n, clk_en, dec_valid, prefix_byte_valid, cond_true, overflow_flag;
  logic        ustep_valid, ustep_word, dec_done, op_word, flags_only, trap_raise, bus_lock;
  logic        coproc_escape, ustep_ready, wb_valid, prev_lock;
  logic [7:0]  prefix_byte, opcode, modrm, branch_offset, off_v;
  logic [15:0] next_ip, count_reg, branch_target, op_clocks, ip_v, n_v;
  logic [5:0]  range_cycles, r_v;
  logic [1:0]  imm_bytes;
  ustep_t      ustep_kind, wb_kind;
  op_class_t   op_class;
  int          fail_count, check_count, cyc;
  dec_exp_t    dq[$];
  step_exp_t   sq[$];

  cisc_opcode_decode_timing #(.CNT_W(16)) i_dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .dec_valid(dec_valid), .prefix_byte_valid(prefix_byte_valid),
    .prefix_byte(prefix_byte), .opcode(opcode), .modrm(modrm), .branch_offset(branch_offset), .next_ip(next_ip),
    .cond_true(cond_true), .overflow_flag(overflow_flag), .count_reg(count_reg), .range_cycles(range_cycles),
    .ustep_valid(ustep_valid), .ustep_kind(ustep_kind), .ustep_word(ustep_word), .dec_done(dec_done),
    .op_class(op_class), .op_word(op_word), .imm_bytes(imm_bytes), .flags_only(flags_only),
    .trap_raise(trap_raise), .bus_lock(bus_lock), .coproc_escape(coproc_escape), .branch_target(branch_target),
    .op_clocks(op_clocks), .ustep_ready(ustep_ready), .wb_valid(wb_valid), .wb_kind(wb_kind));

  // ------------------------------------------------------------------
  // Clock, edge counter, shared tasks
  // ------------------------------------------------------------------
  // Half period of 2.5 ns gives 200 MHz
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // Edge counter lets the monitors judge latency without trusting dut flags
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One decode per call; expectation noted after the accepting edge
  task automatic dec(input logic pv, input logic [7:0] pb, input logic [7:0] op, input logic [7:0] mr,
                     input logic c, input logic o, input logic [15:0] clks, input op_class_t cls);
    dec_exp_t e;
    e.clks = clks;
    e.cls = cls;
    e.lock = (op == 8'hF0) || prev_lock || (pv && pb == 8'hF0);
    e.flg = (cls == CL_AND_FLAGS);
    e.trap = (cls == CL_OVF) && o;
    e.coproc_handoff = (cls == CL_ESC);
    e.tchk = (cls == CL_BRANCH);
    e.tgt = ip_v + {{8{off_v[7]}}, off_v};
    e.ichk = (cls == CL_AND_FLAGS) && (op[7:1] == 7'h7B || op[7:1] == 7'h54);
    e.imm = e.ichk ? (op[0] ? 2'h2 : 2'h1) : 2'h0;
    e.wd = op[0];
    dec_valid <= 1'b1;
    prefix_byte_valid <= pv;
    prefix_byte <= pb;
    opcode <= op;
    modrm <= mr;
    cond_true <= c;
    overflow_flag <= o;
    count_reg <= n_v;
    range_cycles <= r_v;
    branch_offset <= off_v;
    next_ip <= ip_v;
    @(posedge clk);
    e.due = cyc + 1;
    dq.push_back(e);
    prev_lock = (op == 8'hF0);
  endtask

  // Request is held, even while refused, until an edge with ready high
  task automatic step(input ustep_t k, input logic w, input int occ);
    step_exp_t s;
    logic rdy;
    ustep_valid <= 1'b1;
    ustep_kind <= k;
    ustep_word <= w;
    rdy = 1'b0;
    for (int i = 0; i < 40 && !rdy; i++) begin
      @(negedge clk);
      rdy = (ustep_ready === 1'b1);
      @(posedge clk);
    end
    if (!rdy) begin
      fail_count++;
      finish_test();
    end
    s.kind = k;
    s.due = cyc + occ;
    sq.push_back(s);
  endtask

  // ------------------------------------------------------------------
  // Output monitors: oldest note against each result
  // ------------------------------------------------------------------
  always @(negedge clk) begin
    dec_exp_t e;
    step_exp_t s;
    if (arst_n && dec_done === 1'b1) begin
      if (dq.size() == 0) begin
        chk("dec_done_unexpected", 0, 1);
      end else begin
        e = dq.pop_front();
        chk("op_clocks", e.clks, op_clocks);
        chk("op_class", e.cls, op_class);
        chk("dec_cycle", e.due, cyc);
        chk("bus_lock", e.lock, bus_lock);
        chk("flags_only", e.flg, flags_only);
        chk("trap_raise", e.trap, trap_raise);
        chk("coproc_escape", e.coproc_handoff, coproc_escape);
        if (e.tchk) chk("branch_target", e.tgt, branch_target);
        chk("imm_bytes", e.imm, imm_bytes);
        chk("op_word", e.wd, op_word);
      end
    end
    if (arst_n && wb_valid === 1'b1) begin
      if (sq.size() == 0) begin
        chk("wb_unexpected", 0, 1);
      end else begin
        s = sq.pop_front();
        chk("wb_kind", s.kind, wb_kind);
        chk("wb_cycle", s.due, cyc);
      end
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {arst_n, clk_en, dec_valid, prefix_byte_valid, cond_true, overflow_flag, ustep_valid, ustep_word} = 8'h40;
    {prefix_byte, opcode, modrm, branch_offset, off_v} = 40'h00_0000_0000;
    {next_ip, count_reg, ip_v, n_v} = 64'h0000_0000_0000_0000;
    {range_cycles, r_v} = 12'h555;
    ustep_kind = US_ALU;
    prev_lock = 1'b0;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(32'he010_eff9));
    repeat (12) @(posedge clk);
    chk("reset_ready", 1, ustep_ready);
    chk("reset_class", CL_NONE, op_class);
    chk("reset_clocks", 0, op_clocks);
    arst_n <= 1'b1;
    @(posedge clk);
    dec(0, 8'h00, 8'hF6, 8'hD0, 0, 0, 16'h0001, CL_INVERT);
    dec(0, 8'h00, 8'hF7, 8'h16, 0, 0, 16'h0007, CL_INVERT);
    dec(0, 8'h00, 8'h84, 8'hC1, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(0, 8'h00, 8'h85, 8'h07, 0, 0, 16'h0007, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hF6, 8'hC0, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hF7, 8'h06, 0, 0, 16'h0008, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hA8, 8'h00, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hA9, 8'h00, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hA5, 8'h00, 0, 0, 16'h000D, CL_COPY);
    dec(0, 8'h00, 8'h6C, 8'h00, 0, 0, 16'h000D, CL_PORT_IN);
    dec(0, 8'h00, 8'h6F, 8'h00, 0, 0, 16'h000D, CL_PORT_OUT);
    dec(0, 8'h00, 8'hA6, 8'h00, 0, 0, 16'h0012, CL_CMP);
    dec(0, 8'h00, 8'hAB, 8'h00, 0, 0, 16'h0007, CL_FILL);
    for (int i = 0; i < 2; i++) begin
      n_v = (i == 0) ? 16'h0000 : 16'($urandom_range(1, 40));
      dec(1, 8'hF2, 8'hA4, 8'h00, 0, 0, 16'(4 + 9 * n_v), CL_COPY);
      dec(1, 8'hF2, 8'h6D, 8'h00, 0, 0, 16'(5 + 9 * n_v), CL_PORT_IN);
      dec(1, 8'hF2, 8'h6E, 8'h00, 0, 0, 16'(5 + 9 * n_v), CL_PORT_OUT);
      dec(1, 8'hF3, 8'hA7, 8'h00, 0, 0, 16'(4 + 18 * n_v), CL_CMP);
      dec(1, 8'hF2, 8'hAE, 8'h00, 0, 0, 16'(4 + 13 * n_v), CL_SCAN);
    end
    for (int i = 0; i < 32; i++) begin
      off_v = (i == 4) ? 8'h80 : 8'($urandom);
      ip_v = 16'($urandom);
      dec(0, 8'h00, 8'(8'h70 + i % 16), 8'h00, i[4], 0, i[4] ? 16'h0009 : 16'h0001, CL_BRANCH);
    end
    dec(0, 8'h00, 8'hC3, 8'h00, 0, 0, 16'h0010, CL_RET);
    dec(0, 8'h00, 8'hC2, 8'h00, 0, 0, 16'h0010, CL_RET);
    dec(0, 8'h00, 8'hCB, 8'h00, 0, 0, 16'h0017, CL_RET);
    for (int i = 0; i < 6; i++) begin
      dec(0, 8'h00, 8'(8'hE0 + i % 3), 8'h00, i < 3, 0, (i < 3) ? 16'h0010 : 16'h0007, CL_LOOP);
    end
    dec(0, 8'h00, 8'hE3, 8'h00, 1, 0, 16'h000F, CL_BCZ);
    dec(0, 8'h00, 8'hE3, 8'h00, 0, 0, 16'h0007, CL_BCZ);
    dec(0, 8'h00, 8'hCE, 8'h00, 0, 1, 16'h002B, CL_OVF);
    dec(0, 8'h00, 8'hCE, 8'h00, 0, 0, 16'h0004, CL_OVF);
    for (int i = 0; i < 5; i++) begin
      r_v = (i == 0) ? 6'h15 : (i == 1) ? 6'h3C : (i == 3) ? 6'h3F : (i == 4) ? 6'h05 : 6'($urandom_range(21, 60));
      dec(0, 8'h00, 8'h62, 8'($urandom), 0, 0,
          (i == 3) ? 16'h003C : (i == 4) ? 16'h0015 : {10'h000, r_v}, CL_RANGE);
    end
    dec(0, 8'h00, 8'hF0, 8'h00, 0, 0, 16'h0001, CL_LOCK);
    dec(0, 8'h00, 8'h84, 8'hC0, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(0, 8'h00, 8'hA8, 8'h00, 0, 0, 16'h0001, CL_AND_FLAGS);
    dec(1, 8'hF0, 8'h84, 8'hC0, 0, 0, 16'h0001, CL_AND_FLAGS);
    for (int i = 0; i < 8; i++) begin
      dec(0, 8'h00, 8'(8'hD8 + i), 8'($urandom), 0, 0, 16'h0001, CL_ESC);
    end
    for (int i = 0; i < 4; i++) begin
      dec(0, 8'h00, {7'h7B, i[0]}, i[1] ? 8'hF0 : 8'hE0, 0, 0, i[0] ? 16'h0010 : 16'h0008, CL_MULDIV);
    end
    // Frozen clock enable must swallow a decode request outright
    dec_valid <= 1'b0;
    repeat (2) @(posedge clk);
    clk_en <= 1'b0;
    dec_valid <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b1;
    dec_valid <= 1'b0;
    @(posedge clk);
    // Micro-steps back to back; slow ones see the next request refused
    step(US_ALU, 0, 1);
    step(US_MEM, 0, 1);
    step(US_READ, 0, 6);
    step(US_PUSH, 0, 1);
    step(US_PUSH, 0, 5);
    step(US_WRITE, 0, 1);
    step(US_PUSH, 0, 5);
    step(US_MULDIV, 0, 8);
    step(US_MULDIV, 1, 16);
    step(US_REFETCH, 0, 9);
    step(US_ALU, 1, 1);
    ustep_valid <= 1'b0;
    repeat (20) @(posedge clk);
    chk("dec_left", 0, dq.size());
    chk("step_left", 0, sq.size());
    finish_test();
  end

  // Hang guard far above the test's run time
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
endmodule // cisc_opcode_decode_timing_test
